/* File: logic/uab_pkg.sv */
package uab_pkg;

  // Register select codes on the device's register port.
  localparam logic [2:0] REG_BAUD_CONTROL = 3'h0;
  localparam logic [2:0] REG_RECEIVE_STATUS_CONTROL = 3'h1;
  localparam logic [2:0] REG_PERIPHERAL_IRQ_FLAGS = 3'h2;
  localparam logic [2:0] REG_BAUD_DIVISOR_LOW = 3'h3;
  localparam logic [2:0] REG_BAUD_DIVISOR_HIGH = 3'h4;
  localparam logic [2:0] REG_TRANSMIT_HOLDING = 3'h5;
  localparam logic [2:0] REG_TRANSMIT_STATUS_CONTROL = 3'h6;
  localparam logic [2:0] REG_RECEIVE_BUFFER = 3'h7;

  // Bit positions.
  localparam int BIT_AUTOBAUD_OVERFLOW = 7;
  localparam int BIT_RX_IDLE = 6;
  localparam int BIT_WIDE_DIVISOR_SEL = 3;
  localparam int BIT_WAKE_ON_BREAK = 1;
  localparam int BIT_AUTOBAUD_ARM = 0;
  localparam int BIT_HIGH_SPEED_SEL = 2;
  localparam int BIT_RECEIVE_FLAG = 5;

  // Reset values.
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;

  // Base clock dividers of the baud generator and the measurement slow-down.
  localparam int BASE_DIV_SLOW = 64;
  localparam int BASE_DIV_MID = 16;
  localparam int BASE_DIV_FAST = 4;
  localparam int MEAS_DIV = 8;

  // Sync character, its rising edge count, and the counter start value.
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [2:0] SYNC_EDGES = 3'h5;
  localparam logic [15:0] COUNT_START = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Break length in bit times and the frame length with start and stop bits.
  localparam logic [4:0] BREAK_BITS = 5'h0D;
  localparam logic [3:0] FRAME_BITS = 4'hA;

  typedef enum logic [2:0] {
    AB_IDLE,
    AB_WAIT_BREAK,
    AB_WAIT_START,
    AB_WAIT_EDGE1,
    AB_COUNT
  } uab_ab_state_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_BREAK,
    TX_FRAME
  } uab_tx_state_t;

endpackage

/* File: logic/uab_link_if.sv */
interface uab_link_if;
  logic rx_line;

  modport dev (input rx_line);
  modport host (output rx_line);
endinterface

/* File: logic/uab_prescale.sv */
module uab_prescale #(
  parameter int MEAS_DIV = uab_pkg::MEAS_DIV
) (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic wide_sel, // Wide divisor select.
  input wire logic fast_sel, // High speed select.
  input wire logic restart, // Restarts the measurement divider.
  output logic base_tick, // One pulse per base clock period.
  output logic meas_tick // One pulse per measurement clock period.
);

  // The measurement divider counter is four bits wide.
  if (MEAS_DIV < 2 || MEAS_DIV > 16) begin : g_bad_meas_div
    $error("MEAS_DIV out of range");
  end

  typedef struct packed {
    logic [7:0] pre_cnt;
    logic [3:0] meas_cnt;
    logic base_tick;
    logic meas_tick;
  } uab_pre_t;

  uab_pre_t st_ff;
  uab_pre_t nxt_st;
  logic [7:0] last;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    case ({wide_sel, fast_sel})
      2'b00: last = 8'(uab_pkg::BASE_DIV_SLOW - 1);
      2'b11: last = 8'(uab_pkg::BASE_DIV_FAST - 1);
      default: last = 8'(uab_pkg::BASE_DIV_MID - 1);
    endcase
    nxt_st.base_tick = 1'b0;
    nxt_st.meas_tick = 1'b0;
    if (st_ff.pre_cnt >= last) begin
      nxt_st.pre_cnt = 8'h00;
      nxt_st.base_tick = 1'b1;
      if (st_ff.meas_cnt == 4'(MEAS_DIV - 1)) begin
        nxt_st.meas_cnt = 4'h0;
        nxt_st.meas_tick = 1'b1;
      end else begin
        nxt_st.meas_cnt = st_ff.meas_cnt + 4'h1;
      end
    end else begin
      nxt_st.pre_cnt = st_ff.pre_cnt + 8'h01;
    end
    // A tick that belongs to the old phase must not reach the fresh count.
    if (restart) begin
      nxt_st.pre_cnt = 8'h00;
      nxt_st.meas_cnt = 4'h0;
      nxt_st.meas_tick = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign base_tick = st_ff.base_tick;
  assign meas_tick = st_ff.meas_tick;

endmodule

/* File: logic/uab_device.sv */
// Operation
// - Arm bit starts calibration; serial engine held idle.
// - Counting starts at first rising edge after start.
// - Sender transmits sync character with five rising edges.
// - Fifth rising edge stops count into divisor pair.
// - Completion clears arm bit and sets receive flag.
// - Receive buffer read clears flag; data discarded.
// - Software checks high divisor zero for 8-bit.
// - Divisor pair counts as one 16-bit counter.
// - Counter advances at one eighth base rate.
// - Select bits choose base and measurement clock dividers.
// - Wake-on-break defers measurement to byte after break.
// - Counter starts at one; software subtracts one.
// - Software ensures baud rate is measurable at clock.
// - Wide divisor with high speed clear gives Fosc over sixteen times n+1.
module uab_device (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  uab_link_if.dev link, // Serial receive line from the remote sender.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [2:0] reg_addr, // Register select code.
  input wire logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Register read data, valid the cycle after reg_rd.
  output logic serial_hold, // High while the serial engine is held idle.
  output logic baud_tick, // One pulse per baud period outside calibration.
  output logic receive_flag // Receive interrupt flag level.
);

  typedef struct packed {
    logic rx_meta;
    logic rx_in;
    logic rx_prev;
    uab_pkg::uab_ab_state_t ab_state;
    logic [2:0] edge_cnt;
    logic arm;
    logic ovf;
    logic wake;
    logic wide;
    logic hs;
    logic [7:0] receive_status_control;
    logic rx_flag;
    logic [15:0] div;
    logic [15:0] brg_cnt;
    logic baud_tick;
    logic [7:0] rdata;
    logic [7:0] rxbuf;
  } uab_dev_t;

  uab_dev_t st_ff;
  uab_dev_t nxt_st;
  logic rise;
  logic fall;
  logic restart;
  logic base_tick;
  logic meas_tick;
  logic [7:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  uab_prescale #(
    .MEAS_DIV(uab_pkg::MEAS_DIV)
  ) u_prescale (
    .mclk(mclk),
    .rst_n(rst_n),
    .wide_sel(st_ff.wide),
    .fast_sel(st_ff.hs),
    .restart(restart),
    .base_tick(base_tick),
    .meas_tick(meas_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rx_meta = link.rx_line;
    nxt_st.rx_in = st_ff.rx_meta;
    nxt_st.rx_prev = st_ff.rx_in;
    rise = st_ff.rx_in & ~st_ff.rx_prev;
    fall = ~st_ff.rx_in & st_ff.rx_prev;
    restart = 1'b0;
    nxt_st.baud_tick = 1'b0;

    rd_val = 8'h00;
    case (reg_addr)
      uab_pkg::REG_BAUD_CONTROL: begin
        rd_val[uab_pkg::BIT_AUTOBAUD_OVERFLOW] = st_ff.ovf;
        rd_val[uab_pkg::BIT_RX_IDLE] = (st_ff.ab_state == uab_pkg::AB_IDLE) & st_ff.rx_in;
        rd_val[uab_pkg::BIT_WIDE_DIVISOR_SEL] = st_ff.wide;
        rd_val[uab_pkg::BIT_WAKE_ON_BREAK] = st_ff.wake;
        rd_val[uab_pkg::BIT_AUTOBAUD_ARM] = st_ff.arm;
      end
      uab_pkg::REG_RECEIVE_STATUS_CONTROL: rd_val = st_ff.receive_status_control;
      uab_pkg::REG_PERIPHERAL_IRQ_FLAGS: rd_val[uab_pkg::BIT_RECEIVE_FLAG] = st_ff.rx_flag;
      uab_pkg::REG_BAUD_DIVISOR_LOW: rd_val = st_ff.div[7:0];
      uab_pkg::REG_BAUD_DIVISOR_HIGH: rd_val = st_ff.div[15:8];
      uab_pkg::REG_TRANSMIT_STATUS_CONTROL: rd_val[uab_pkg::BIT_HIGH_SPEED_SEL] = st_ff.hs;
      uab_pkg::REG_RECEIVE_BUFFER: rd_val = st_ff.rxbuf;
      default: rd_val = 8'h00;
    endcase
    if (reg_rd) begin
      nxt_st.rdata = rd_val;
      if (reg_addr == uab_pkg::REG_RECEIVE_BUFFER) begin
        nxt_st.rx_flag = 1'b0;
      end
    end

    // Software writes come first so that hardware events below win.
    if (reg_wr) begin
      case (reg_addr)
        uab_pkg::REG_BAUD_CONTROL: begin
          nxt_st.ovf = reg_wdata[uab_pkg::BIT_AUTOBAUD_OVERFLOW];
          nxt_st.wide = reg_wdata[uab_pkg::BIT_WIDE_DIVISOR_SEL];
          nxt_st.wake = reg_wdata[uab_pkg::BIT_WAKE_ON_BREAK];
          nxt_st.arm = reg_wdata[uab_pkg::BIT_AUTOBAUD_ARM];
          if (reg_wdata[uab_pkg::BIT_AUTOBAUD_ARM]) begin
            if (st_ff.ab_state == uab_pkg::AB_IDLE) begin
              if (reg_wdata[uab_pkg::BIT_WAKE_ON_BREAK]) begin
                nxt_st.ab_state = uab_pkg::AB_WAIT_BREAK;
              end else begin
                nxt_st.ab_state = uab_pkg::AB_WAIT_START;
              end
            end
          end else begin
            nxt_st.ab_state = uab_pkg::AB_IDLE;
          end
        end
        uab_pkg::REG_RECEIVE_STATUS_CONTROL: nxt_st.receive_status_control = reg_wdata;
        uab_pkg::REG_BAUD_DIVISOR_LOW: begin
          if (st_ff.ab_state == uab_pkg::AB_IDLE) begin
            nxt_st.div[7:0] = reg_wdata;
          end
        end
        uab_pkg::REG_BAUD_DIVISOR_HIGH: begin
          if (st_ff.ab_state == uab_pkg::AB_IDLE) begin
            nxt_st.div[15:8] = reg_wdata;
          end
        end
        uab_pkg::REG_TRANSMIT_STATUS_CONTROL: nxt_st.hs = reg_wdata[uab_pkg::BIT_HIGH_SPEED_SEL];
        default: nxt_st.receive_status_control = nxt_st.receive_status_control;
      endcase
    end

    case (st_ff.ab_state)
      uab_pkg::AB_IDLE: begin
        if (base_tick) begin
          if (st_ff.brg_cnt == 16'h0000) begin
            nxt_st.baud_tick = 1'b1;
            nxt_st.brg_cnt = st_ff.wide ? st_ff.div : {8'h00, st_ff.div[7:0]};
          end else begin
            nxt_st.brg_cnt = st_ff.brg_cnt - 16'h0001;
          end
        end
      end
      uab_pkg::AB_WAIT_BREAK: begin
        // The end of the low break period releases the wait.
        if (rise) begin
          nxt_st.wake = 1'b0;
          nxt_st.ab_state = uab_pkg::AB_WAIT_START;
        end
      end
      uab_pkg::AB_WAIT_START: begin
        if (fall) begin
          nxt_st.ab_state = uab_pkg::AB_WAIT_EDGE1;
        end
      end
      uab_pkg::AB_WAIT_EDGE1: begin
        if (rise) begin
          restart = 1'b1;
          nxt_st.div = uab_pkg::COUNT_START;
          nxt_st.edge_cnt = 3'h1;
          nxt_st.ab_state = uab_pkg::AB_COUNT;
        end
      end
      uab_pkg::AB_COUNT: begin
        if (meas_tick) begin
          if (st_ff.div == uab_pkg::COUNT_MAX) begin
            nxt_st.ovf = 1'b1;
          end
          nxt_st.div = st_ff.div + 16'h0001;
        end
        if (rise) begin
          nxt_st.edge_cnt = st_ff.edge_cnt + 3'h1;
          if (st_ff.edge_cnt == uab_pkg::SYNC_EDGES - 3'h1) begin
            nxt_st.div = st_ff.div;
            nxt_st.arm = 1'b0;
            nxt_st.rx_flag = 1'b1;
            nxt_st.brg_cnt = 16'h0000;
            nxt_st.ab_state = uab_pkg::AB_IDLE;
          end
        end
      end
      default: nxt_st.ab_state = uab_pkg::AB_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{
        rx_meta: 1'b1,
        rx_in: 1'b1,
        rx_prev: 1'b1,
        ab_state: uab_pkg::AB_IDLE,
        edge_cnt: 3'h0,
        arm: 1'b0,
        ovf: 1'b0,
        wake: 1'b0,
        wide: 1'b0,
        hs: 1'b0,
        receive_status_control: uab_pkg::RECEIVE_STATUS_CONTROL_RESET,
        rx_flag: 1'b0,
        div: uab_pkg::DIVISOR_RESET,
        brg_cnt: 16'h0000,
        baud_tick: 1'b0,
        rdata: 8'h00,
        rxbuf: 8'h00
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign serial_hold = (st_ff.ab_state != uab_pkg::AB_IDLE);
  assign baud_tick = st_ff.baud_tick;
  assign receive_flag = st_ff.rx_flag;

endmodule

/* File: logic/uab_host.sv */
module uab_host (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  uab_link_if.host link, // Serial line driven toward the device.
  input wire logic send, // Pulse: send one sync character.
  input wire logic with_break, // Precede the sync character with a break.
  input wire logic [15:0] bit_cycles, // Clock cycles per bit, at least one.
  output logic busy // High while a transfer is in progress.
);

  typedef struct packed {
    uab_pkg::uab_tx_state_t state;
    logic [15:0] cyc;
    logic [4:0] bit_idx;
    logic [9:0] shift;
    logic line;
  } uab_host_t;

  uab_host_t st_ff;
  uab_host_t nxt_st;
  logic bit_end;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    bit_end = (st_ff.cyc <= 16'h0001);
    nxt_st.cyc = bit_end ? bit_cycles : st_ff.cyc - 16'h0001;
    case (st_ff.state)
      uab_pkg::TX_IDLE: begin
        nxt_st.line = 1'b1;
        nxt_st.cyc = bit_cycles;
        nxt_st.bit_idx = 5'h00;
        nxt_st.shift = {1'b1, uab_pkg::SYNC_CHAR, 1'b0};
        if (send) begin
          nxt_st.state = with_break ? uab_pkg::TX_BREAK : uab_pkg::TX_FRAME;
          nxt_st.line = with_break ? 1'b0 : 1'b0;
        end
      end
      uab_pkg::TX_BREAK: begin
        // Break: low for the break length, then one high delimiter bit.
        if (bit_end) begin
          nxt_st.bit_idx = st_ff.bit_idx + 5'h01;
          nxt_st.line = (st_ff.bit_idx >= uab_pkg::BREAK_BITS - 5'h01);
          if (st_ff.bit_idx == uab_pkg::BREAK_BITS) begin
            nxt_st.bit_idx = 5'h00;
            nxt_st.line = 1'b0;
            nxt_st.state = uab_pkg::TX_FRAME;
          end
        end
      end
      uab_pkg::TX_FRAME: begin
        if (bit_end) begin
          nxt_st.shift = {1'b1, st_ff.shift[9:1]};
          nxt_st.line = st_ff.shift[1];
          nxt_st.bit_idx = st_ff.bit_idx + 5'h01;
          if (st_ff.bit_idx == 5'({1'b0, uab_pkg::FRAME_BITS} - 5'h01)) begin
            nxt_st.line = 1'b1;
            nxt_st.state = uab_pkg::TX_IDLE;
          end
        end
      end
      default: nxt_st.state = uab_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{
        state: uab_pkg::TX_IDLE,
        cyc: 16'h0000,
        bit_idx: 5'h00,
        shift: 10'h3FF,
        line: 1'b1
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.rx_line = st_ff.line;
  assign busy = (st_ff.state != uab_pkg::TX_IDLE);

endmodule

/* File: verification/uab_link_assertions.sv */
module uab_link_assertions (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic rx_line, // Serial line between the two ends.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [2:0] reg_addr, // Register select code.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic serial_hold, // Serial engine held idle.
  input wire logic baud_tick, // Baud period pulse.
  input wire logic receive_flag, // Receive interrupt flag.
  input wire logic send, // Host send pulse.
  input wire logic with_break, // Host break request.
  input wire logic busy // Host transfer in progress.
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic rd_buf;
  assign rd_buf = reg_rd && reg_addr == uab_pkg::REG_RECEIVE_BUFFER;

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  hold_on_arm_a: assert property (reg_wr && reg_addr == uab_pkg::REG_BAUD_CONTROL &&
    reg_wdata[uab_pkg::BIT_AUTOBAUD_ARM] |=> serial_hold) else $error("arm write did not hold engine");
  no_tick_hold_a: assert property (serial_hold && $past(serial_hold) |-> !baud_tick)
    else $error("baud tick while calibrating");
  flag_on_done_a: assert property ($fell(serial_hold) && !$past(reg_wr) |-> receive_flag)
    else $error("calibration ended without receive flag");
  flag_cause_a: assert property ($rose(receive_flag) |-> $past(serial_hold))
    else $error("receive flag rose outside calibration");
  flag_clear_a: assert property (rd_buf && !serial_hold |=> !receive_flag)
    else $error("receive buffer read did not clear flag");
  flag_sticky_a: assert property (receive_flag && !rd_buf |=> receive_flag)
    else $error("receive flag dropped without read");
  line_idle_a: assert property (!busy |-> rx_line) else $error("line low while sender idle");
  start_low_a: assert property (send && !busy |=> !rx_line && busy)
    else $error("send did not start a frame");
  frame_min_a: assert property ($rose(busy) |-> busy [*8]) else $error("frame too short");

  cover_done_c: cover property ($fell(serial_hold) && receive_flag);
  cover_clear_c: cover property (rd_buf && receive_flag);
  cover_break_c: cover property (send && with_break && !busy);
endmodule

/* File: verification/uab_autobaud_detect_tb_top.sv */
module uab_autobaud_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst_n, reg_wr, reg_rd, send, with_break;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic serial_hold, baud_tick, receive_flag, busy;
  logic [15:0] bit_cycles;
  int err_total, checks, seed;

  uab_link_if lnk ();

  uab_device uab_device_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_hold(serial_hold),
    .baud_tick(baud_tick), .receive_flag(receive_flag));
  uab_host uab_host_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk), .send(send), .with_break(with_break),
    .bit_cycles(bit_cycles), .busy(busy));
  uab_link_assertions uab_link_assertions_inst (.mclk(mclk), .rst_n(rst_n), .rx_line(lnk.rx_line),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_hold(serial_hold),
    .baud_tick(baud_tick), .receive_flag(receive_flag), .send(send), .with_break(with_break), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail(string m);
    $display("ERROR %0t %s", $time, m);
    err_total++;
  endtask

  task automatic chk8(logic [7:0] got, logic [7:0] exp, string m);
    checks++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk_int(int got, int exp, string m);
    checks++;
    if (got !== exp) fail(m);
  endtask

  // The prescaler phase at the first edge may shift the count by one tick.
  task automatic chk_div(logic [15:0] got, int exp, string m);
    checks++;
    if (!(got === 16'(exp) || got === 16'(exp + 1) || got === 16'(exp - 1))) fail(m);
  endtask

  function automatic int base_of(logic w, logic h);
    return (w && h) ? uab_pkg::BASE_DIV_FAST : ((w || h) ? uab_pkg::BASE_DIV_MID : uab_pkg::BASE_DIV_SLOW);
  endfunction

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic rd_div(output logic [15:0] v);
    logic [7:0] l, h;
    rd(uab_pkg::REG_BAUD_DIVISOR_LOW, l);
    rd(uab_pkg::REG_BAUD_DIVISOR_HIGH, h);
    v = {h, l};
  endtask

  task automatic wait_for(input bit want_flag);
    int n;
    n = 0;
    while ((want_flag ? receive_flag !== 1'b1 : busy !== 1'b0) && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40000) begin
      fail("wait timed out");
      finish_test;
    end
  endtask

  task automatic tick_gap(output int n);
    int t;
    t = 0;
    while (baud_tick !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    n = 0;
    @(negedge mclk);
    while (baud_tick !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (t >= 2000 || n >= 2000) begin
      fail("baud tick timed out");
      finish_test;
    end
    n++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic calibrate(logic w, logic h, logic brk);
    int k;
    logic [7:0] d;
    logic [15:0] v;
    k = 2 + {$random(seed)} % 8;
    wr(uab_pkg::REG_TRANSMIT_STATUS_CONTROL, 8'(h) << uab_pkg::BIT_HIGH_SPEED_SEL);
    wr(uab_pkg::REG_BAUD_CONTROL, (8'(w) << uab_pkg::BIT_WIDE_DIVISOR_SEL) |
      (8'(brk) << uab_pkg::BIT_WAKE_ON_BREAK) | 8'h01);
    chk8({7'h00, serial_hold}, 8'h01, "engine not held after arm");
    wr(uab_pkg::REG_BAUD_DIVISOR_LOW, 8'hAA);
    @(negedge mclk);
    send = 1'b1;
    with_break = brk;
    bit_cycles = 16'(k * base_of(w, h));
    @(negedge mclk);
    send = 1'b0;
    wait_for(1'b1);
    rd(uab_pkg::REG_BAUD_CONTROL, d);
    chk8(d & 8'h01, 8'h00, "arm bit not cleared");
    chk8(d & 8'h80, 8'h00, "overflow set on short count");
    chk8({7'h00, serial_hold}, 8'h00, "engine still held");
    rd_div(v);
    chk_div(v, k + 1, "measured divisor wrong");
    rd(uab_pkg::REG_RECEIVE_BUFFER, d);
    chk8({7'h00, receive_flag}, 8'h00, "flag not cleared by buffer read");
    wait_for(1'b0);
  endtask

  initial begin
    logic [7:0] d;
    int n;
    seed = 25232;
    err_total = 0;
    checks = 0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    send = 1'b0;
    with_break = 1'b0;
    bit_cycles = 16'h0001;
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    rd(uab_pkg::REG_BAUD_DIVISOR_HIGH, d);
    chk8(d, 8'h00, "divisor high reset value");
    rd(uab_pkg::REG_RECEIVE_STATUS_CONTROL, d);
    chk8(d, uab_pkg::RECEIVE_STATUS_CONTROL_RESET, "receive status reset value");
    rd(uab_pkg::REG_BAUD_CONTROL, d);
    chk8(d & 8'hBF, 8'h00, "baud control reset value");
    for (int m = 0; m < 4; m++) calibrate(m[1], m[0], 1'b0);
    calibrate(1'b1, 1'b0, 1'b1);
    wr(uab_pkg::REG_BAUD_CONTROL, 8'h01);
    wr(uab_pkg::REG_BAUD_CONTROL, 8'h00);
    chk8({7'h00, serial_hold, receive_flag}, 8'h00, "abort left engine held");
    wr(uab_pkg::REG_BAUD_CONTROL, 8'h08);
    wr(uab_pkg::REG_BAUD_DIVISOR_LOW, 8'h05);
    wr(uab_pkg::REG_BAUD_DIVISOR_HIGH, 8'h00);
    rd(uab_pkg::REG_BAUD_DIVISOR_LOW, d);
    chk8(d, 8'h05, "divisor low readback");
    tick_gap(n);
    tick_gap(n);
    chk_int(n, 6 * uab_pkg::BASE_DIV_MID, "wide divisor baud period");
    wr(uab_pkg::REG_BAUD_CONTROL, 8'h00);
    wr(uab_pkg::REG_BAUD_DIVISOR_LOW, 8'h01);
    wr(uab_pkg::REG_BAUD_DIVISOR_HIGH, 8'h01);
    tick_gap(n);
    tick_gap(n);
    chk_int(n, 2 * uab_pkg::BASE_DIV_SLOW, "narrow divisor baud period");
    finish_test;
  end
endmodule
